// ===== common/wbl_pkg.sv
// constants, register map and operation types of the work bit logic cell
package wbl_pkg;
	// structure of the cell array
	localparam int NUM_BITS = 8;
	localparam int NUM_IN = 4;
	localparam int NUM_EVT = 4;
	localparam int NUM_COND = 34;
	localparam int CODE_W = 6;
	localparam int SRC_COUNT = 49;
	localparam int DLY_W = 14;
	localparam logic [DLY_W-1:0] DLY_MAX = 14'h270f;
	localparam logic [DLY_W-1:0] DLY_ZERO = 14'h0000;
	localparam logic [DLY_W-1:0] DLY_STEP = 14'h0001;

	// input source codes
	localparam int SRC_OFF = 0;
	localparam int SRC_ON = 1;
	localparam int SRC_PULSE = 2;
	localparam int SRC_EVT_BASE = 3;
	localparam int SRC_COND_BASE = 7;
	localparam int SRC_WB_BASE = 41;

	// register bus, word addressed
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_SEL_W = 2;
	localparam int BIT_SEL_LSB = 2;
	localparam int BIT_SEL_W = 3;
	localparam logic [REG_SEL_W-1:0] REG_OP = 2'h0;
	localparam logic [REG_SEL_W-1:0] REG_SRC = 2'h1;
	localparam logic [REG_SEL_W-1:0] REG_ON = 2'h2;
	localparam logic [REG_SEL_W-1:0] REG_OFF = 2'h3;
	localparam logic [ADDR_W-1:0] MAP_LIMIT = 8'h20;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;

	// field layout
	localparam int OP_LSB = 0;
	localparam int OP_W = 3;
	localparam int INV_LSB = 4;
	localparam int SRC_FIELD_STRIDE = 8;
	localparam int DLY_LSB = 0;
	localparam int STATUS_WB_LSB = 0;
	localparam int STATUS_RES_LSB = 8;

	// timing: one delay unit is one second
	localparam int CLOCK_PERIOD_NS = 50;
	localparam int UNIT_TIME_MS = 1000;
	localparam int UNIT_CYCLES = UNIT_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
	localparam int PRESC_W = 25;

	typedef enum logic [2:0] {OP_NONE, OP_AND_OR, OP_OR_AND, OP_ANY, OP_ALL} wbl_op_type;
endpackage

// ===== hw/wbl_input_sel.sv
// source selection and polarity of one logic input
`timescale 1ns/100ps
module wbl_input_sel (
	input wire logic [wbl_pkg::SRC_COUNT-1:0] srcVec,
	input wire logic [wbl_pkg::CODE_W-1:0] code,
	input wire logic invert,
	output logic sel
);
	import wbl_pkg::*;

	// unknown codes read as false before polarity is applied
	always_comb begin
		sel = 1'b0;
		if (code < SRC_COUNT) begin
			sel = srcVec[code];
		end
		sel = sel ^ invert;
	end
endmodule

// ===== hw/wbl_delay.sv
// on and off delay stage holding one work bit
`timescale 1ns/100ps
module wbl_delay (
	input wire logic clock,
	input wire logic rst,
	input wire logic opRes,
	input wire logic tick,
	input wire logic [wbl_pkg::DLY_W-1:0] onDly,
	input wire logic [wbl_pkg::DLY_W-1:0] offDly,
	output logic workBit
);
	import wbl_pkg::*;

	logic state_q;
	logic [DLY_W-1:0] count_q;
	logic [DLY_W-1:0] target;

	// rising result waits on the on delay, falling on the off delay
	assign target = opRes ? onDly : offDly;
	assign workBit = state_q;

	// state follows the result once enough units have passed
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= 1'b0;
		end else if (opRes != state_q) begin
			if (target == DLY_ZERO || count_q > target) begin
				state_q <= opRes;
			end
		end
	end

	// shared tick makes the first unit partial, so one extra tick is counted:
	// the bit never moves early unless the result reverses in the cycle the bit moves, as the count is kept; at worst one unit late
	always_ff @(posedge clock) begin
		if (rst || opRes == state_q) begin
			count_q <= DLY_ZERO;
		end else if (tick && count_q <= target) begin
			count_q <= count_q + DLY_STEP;
		end
	end
endmodule

// ===== hw/wbl_top.sv
// array of configurable work bit logic cells with register port
//
// Contract
// - each work bit selects one of four operations on A to D or none.
// - no operation, the reset default, keeps the work bit off.
// - operation 1 is (A and B) or (C and D).
// - operation 2 is (A or C) and (B or D).
// - operation 3 is A or B or C or D.
// - operation 4 is A and B and C and D.
// - source code 0 is false, 1 true, 2 one cycle after power-up.
// - every input may be inverted before the operation.
// - a rising result waits the on delay, 0 to 9999 units, 0 none; a rise in the cycle the bit falls starts from the off delay count.
// - a falling result waits the off delay, 0 to 9999 units, 0 none; a fall in the cycle the bit rises starts from the on delay count.
`timescale 1ns/100ps
module wbl_top #(
	parameter int UNIT_CYCLES = wbl_pkg::UNIT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [wbl_pkg::ADDR_W-1:0] addr,
	input wire logic [wbl_pkg::DATA_W-1:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [wbl_pkg::DATA_W-1:0] readData,
	input wire logic [wbl_pkg::NUM_EVT-1:0] evPin,
	input wire logic [wbl_pkg::NUM_COND-1:0] condIn,
	output logic [wbl_pkg::NUM_BITS-1:0] workBit
);
	import wbl_pkg::*;

	localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(UNIT_CYCLES - 1);
	localparam logic [PRESC_W-1:0] PRESC_ZERO = '0;
	localparam logic [PRESC_W-1:0] PRESC_STEP = PRESC_W'(1);

	// configuration
	wbl_op_type opSel_q [NUM_BITS];
	logic [NUM_IN-1:0] inv_q [NUM_BITS];
	logic [CODE_W-1:0] code_q [NUM_BITS][NUM_IN];
	logic [DLY_W-1:0] onDly_q [NUM_BITS];
	logic [DLY_W-1:0] offDly_q [NUM_BITS];

	// datapath
	logic [NUM_EVT-1:0] evS1_q;
	logic [NUM_EVT-1:0] evS2_q;
	logic [NUM_EVT-1:0] evS3_q;
	logic [NUM_EVT-1:0] evF_q;
	logic started_q;
	logic pulse_q;
	logic [PRESC_W-1:0] presc_q;
	logic tick_q;
	logic [SRC_COUNT-1:0] allSrc;
	logic [NUM_IN-1:0] opIn [NUM_BITS];
	logic [NUM_BITS-1:0] opRes_d;
	logic [NUM_BITS-1:0] opRes_q;
	logic [NUM_BITS-1:0] wbState;

	// register port
	logic [BIT_SEL_W-1:0] bitSel;
	logic [REG_SEL_W-1:0] regSel;
	logic inMap;
	logic [DATA_W-1:0] readMux;
	logic [DATA_W-1:0] readData_q;
	logic [OP_W-1:0] opField;
	logic [DLY_W-1:0] dlyField;
	logic [DLY_W-1:0] dlyClamped;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// event pins: three stages, a change counts once stages two and three agree
	always_ff @(posedge clock) begin
		if (rst) begin
			evS1_q <= '0;
			evS2_q <= '0;
			evS3_q <= '0;
		end else begin
			evS1_q <= evPin;
			evS2_q <= evS1_q;
			evS3_q <= evS2_q;
		end
	end

	generate
		for (genvar e = 0; e < NUM_EVT; e++) begin : g_evt
			// filtered level only moves when the last two stages match
			always_ff @(posedge clock) begin
				if (rst) begin
					evF_q[e] <= 1'b0;
				end else if (evS2_q[e] == evS3_q[e]) begin
					evF_q[e] <= evS3_q[e];
				end
			end
		end
	endgenerate

	// power-up pulse: high for exactly the first cycle after reset release
	always_ff @(posedge clock) begin
		if (rst) begin
			started_q <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			started_q <= 1'b1;
			pulse_q <= !started_q;
		end
	end

	// delay time base, one tick per unit shared by all cells
	always_ff @(posedge clock) begin
		if (rst) begin
			presc_q <= PRESC_ZERO;
			tick_q <= 1'b0;
		end else if (presc_q == PRESC_LAST) begin
			presc_q <= PRESC_ZERO;
			tick_q <= 1'b1;
		end else begin
			presc_q <= presc_q + PRESC_STEP;
			tick_q <= 1'b0;
		end
	end

	// source vector indexed by code; work bits feed back as registered values
	assign allSrc = {wbState, condIn, evF_q, pulse_q, 1'b1, 1'b0};
	assign workBit = wbState;

	generate
		for (genvar g = 0; g < NUM_BITS; g++) begin : g_cell
			for (genvar j = 0; j < NUM_IN; j++) begin : g_in
				wbl_input_sel u_sel (
					.srcVec(allSrc),
					.code(code_q[g][j]),
					.invert(inv_q[g][j]),
					.sel(opIn[g][j])
				);
			end

			// operation on inputs A..D (bits 0..3)
			always_comb begin
				opRes_d[g] = 1'b0;
				unique case (opSel_q[g])
					OP_NONE: opRes_d[g] = 1'b0;
					OP_AND_OR: opRes_d[g] = (opIn[g][0] && opIn[g][1]) ||
						(opIn[g][2] && opIn[g][3]);
					OP_OR_AND: opRes_d[g] = (opIn[g][0] || opIn[g][2]) &&
						(opIn[g][1] || opIn[g][3]);
					OP_ANY: opRes_d[g] = |opIn[g];
					OP_ALL: opRes_d[g] = &opIn[g];
					default: opRes_d[g] = 1'b0;
				endcase
			end

			// one evaluation per cycle keeps feedback loops free of combinational paths
			always_ff @(posedge clock) begin
				if (rst) begin
					opRes_q[g] <= 1'b0;
				end else begin
					opRes_q[g] <= opRes_d[g];
				end
			end

			wbl_delay u_dly (
				.clock(clock),
				.rst(rst),
				.opRes(opRes_q[g]),
				.tick(tick_q),
				.onDly(onDly_q[g]),
				.offDly(offDly_q[g]),
				.workBit(wbState[g])
			);

			sequence riseStart;
				opRes_q[g] && !$past(opRes_q[g]) && !wbState[g];
			endsequence

			sequence fallStart;
				!opRes_q[g] && $past(opRes_q[g]) && wbState[g];
			endsequence

			chk_noop_holds_off: assert property (opSel_q[g] == OP_NONE |=> !opRes_q[g])
				else $error("no operation did not hold result off");
			chk_op_and_or: assert property (opSel_q[g] == OP_AND_OR |=> opRes_q[g] ==
				$past((opIn[g][0] && opIn[g][1]) || (opIn[g][2] && opIn[g][3])))
				else $error("operation 1 result wrong");
			chk_op_or_and: assert property (opSel_q[g] == OP_OR_AND |=> opRes_q[g] ==
				$past((opIn[g][0] || opIn[g][2]) && (opIn[g][1] || opIn[g][3])))
				else $error("operation 2 result wrong");
			chk_op_any: assert property (opSel_q[g] == OP_ANY |=>
				opRes_q[g] == $past(|opIn[g]))
				else $error("operation 3 result wrong");
			chk_op_all: assert property (opSel_q[g] == OP_ALL |=>
				opRes_q[g] == $past(&opIn[g]))
				else $error("operation 4 result wrong");
			chk_input_polarity: assert property (code_q[g][0] < SRC_COUNT |->
				opIn[g][0] == (allSrc[code_q[g][0]] ^ inv_q[g][0]))
				else $error("input A polarity wrong");
			chk_on_zero_follow: assert property (opRes_q[g] && !wbState[g] &&
				onDly_q[g] == DLY_ZERO |=> wbState[g])
				else $error("zero on delay did not follow at once");
			chk_on_delay_wait: assert property (riseStart ##0 onDly_q[g] != DLY_ZERO
				|=> !wbState[g])
				else $error("on delay did not hold work bit off");
			chk_off_zero_follow: assert property (!opRes_q[g] && wbState[g] &&
				offDly_q[g] == DLY_ZERO |=> !wbState[g])
				else $error("zero off delay did not follow at once");
			chk_off_delay_wait: assert property (fallStart ##0 offDly_q[g] != DLY_ZERO
				|=> wbState[g])
				else $error("off delay did not hold work bit on");
			chk_bit_from_result: assert property ($changed(wbState[g]) |->
				wbState[g] == $past(opRes_q[g]))
				else $error("work bit moved without registered result");
		end
	endgenerate

	sequence relRelease;
		rst ##1 !rst;
	endsequence

	chk_pulse_after_reset: assert property (@(posedge clock) disable iff (1'b0)
		relRelease |=> pulse_q ##1 !pulse_q [*8])
		else $error("power-up pulse not exactly one cycle");
	chk_pulse_single: assert property (pulse_q |=> !pulse_q [*8])
		else $error("power-up pulse repeated");

	// address decode, word per register, four per work bit
	assign bitSel = addr[BIT_SEL_LSB +: BIT_SEL_W];
	assign regSel = addr[REG_SEL_W-1:0];
	assign inMap = addr < MAP_LIMIT;
	assign opField = writeData[OP_LSB +: OP_W];
	assign dlyField = writeData[DLY_LSB +: DLY_W];
	assign dlyClamped = (dlyField > DLY_MAX) ? DLY_MAX : dlyField;

	// configuration writes; illegal operation codes fall back to none
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int b = 0; b < NUM_BITS; b++) begin
				opSel_q[b] <= OP_NONE;
				inv_q[b] <= '0;
				onDly_q[b] <= DLY_ZERO;
				offDly_q[b] <= DLY_ZERO;
				for (int j = 0; j < NUM_IN; j++) begin
					code_q[b][j] <= '0;
				end
			end
		end else if (writeStrobe && inMap) begin
			unique case (regSel)
				REG_OP: begin
					opSel_q[bitSel] <= (opField > OP_W'(OP_ALL)) ? OP_NONE :
						wbl_op_type'(opField);
					inv_q[bitSel] <= writeData[INV_LSB +: NUM_IN];
				end
				REG_SRC: begin
					for (int j = 0; j < NUM_IN; j++) begin
						code_q[bitSel][j] <= writeData[j*SRC_FIELD_STRIDE +: CODE_W];
					end
				end
				REG_ON: onDly_q[bitSel] <= dlyClamped;
				REG_OFF: offDly_q[bitSel] <= dlyClamped;
			endcase
		end
	end

	// read mux; unmapped addresses and reserved bits read zero
	always_comb begin
		readMux = '0;
		if (inMap) begin
			unique case (regSel)
				REG_OP: begin
					readMux[OP_LSB +: OP_W] = opSel_q[bitSel];
					readMux[INV_LSB +: NUM_IN] = inv_q[bitSel];
				end
				REG_SRC: begin
					for (int j = 0; j < NUM_IN; j++) begin
						readMux[j*SRC_FIELD_STRIDE +: CODE_W] = code_q[bitSel][j];
					end
				end
				REG_ON: readMux[DLY_LSB +: DLY_W] = onDly_q[bitSel];
				REG_OFF: readMux[DLY_LSB +: DLY_W] = offDly_q[bitSel];
			endcase
		end else if (addr == REG_STATUS) begin
			readMux[STATUS_WB_LSB +: NUM_BITS] = wbState;
			readMux[STATUS_RES_LSB +: NUM_BITS] = opRes_q;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			readData_q <= '0;
		end else if (readStrobe) begin
			readData_q <= readMux;
		end else begin
			readData_q <= '0;
		end
	end

	assign readData = readData_q;

	chk_op_readback: assert property (writeStrobe && inMap && regSel == REG_OP &&
		writeData[OP_LSB +: OP_W] <= OP_W'(OP_ALL) ##1 readStrobe && $stable(addr)
		|=> readData[OP_LSB +: OP_W] == $past(writeData[OP_LSB +: OP_W], 2))
		else $error("operation type readback wrong");
	chk_read_one_cycle: assert property (!readStrobe |=> readData == '0)
		else $error("read data outside read cycle");
endmodule

// ===== dv/wbl_top_tb_top.sv
// self-checking bench for the work bit logic cell array
`timescale 1ns/100ps
module wbl_top_tb_top;
	import wbl_pkg::*;
	// short delay unit so that delay scenarios stay brief
	localparam int UNIT = 10;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = 8'h00;
	logic [DATA_W-1:0] writeData = 32'h0;
	logic writeStrobe = 1'b0;
	logic readStrobe = 1'b0;
	logic [DATA_W-1:0] readData;
	logic [NUM_EVT-1:0] evPin = 4'h0;
	logic [NUM_COND-1:0] condIn = 34'h0;
	logic [NUM_BITS-1:0] workBit;
	logic seen;
	int errCount = 0;
	int comparisons = 0;
	int n;

	wbl_top #(.UNIT_CYCLES(UNIT)) wbl_top_i (
		.clock(clock),
		.rst(rst),
		.addr(addr),
		.writeData(writeData),
		.writeStrobe(writeStrobe),
		.readStrobe(readStrobe),
		.readData(readData),
		.evPin(evPin),
		.condIn(condIn),
		.workBit(workBit)
	);

	// free running clock
	always #25 clock = ~clock;

	// verdict and end of run
	task automatic results();
		$display("comparisons %0d errors %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// compare tasks, one per result kind
	task automatic cmpData(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// register port cycles; read data stand only in the cycle after the strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		addr <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clock);
		addr <= a;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1;
		cmpData(readData, exp);
	endtask

	// write then read of one address with no gap between the strobes
	task automatic wrRd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [DATA_W-1:0] exp);
		@(posedge clock);
		addr <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clock);
		writeStrobe <= 1'b0;
		readStrobe <= 1'b1;
		@(posedge clock);
		readStrobe <= 1'b0;
		#1;
		cmpData(readData, exp);
	endtask

	// bounded wait for a work bit level; a timeout ends the run
	task automatic waitBit(input int idx, input logic val, output int cnt);
		cnt = 0;
		while (workBit[idx] !== val && cnt < 2000) begin
			@(posedge clock);
			#1;
			cnt++;
		end
		if (cnt >= 2000) begin
			errCount++;
			results();
		end
	endtask

	// drive the four conditions of cell 0, let the two-stage path settle, compare
	task automatic setChk(input logic [3:0] v, input logic exp);
		@(posedge clock);
		condIn[3:0] <= v;
		repeat (4) @(posedge clock);
		#1;
		cmpBit(workBit[0], exp);
	endtask

	// reference of the four operations, A in bit 0
	function automatic logic opf(input int op, input logic [3:0] v);
		case (op)
			1: return (v[0] & v[1]) | (v[2] & v[3]);
			2: return (v[0] | v[2]) & (v[1] | v[3]);
			3: return |v;
			4: return &v;
			default: return 1'b0;
		endcase
	endfunction

	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		#1;
		cmpData(32'(workBit), 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h21, 32'h0);
		// cell 7 gets operation 2 on false inputs, read back at once
		wrRd(8'h1c, 32'h2, 32'h2);
		// inputs A to D of cell 0 taken from condIn[0..3]
		wr(8'h01, 32'h0a090807);
		for (int op = 0; op < 5; op++) begin
			wr(8'h00, 32'(op));
			for (int v = 0; v < 16; v++) begin
				setChk(4'(v), opf(op, 4'(v)));
			end
		end
		// an undefined operation code falls back to none
		wr(8'h00, 32'h7);
		rd(8'h00, 32'h0);
		// all-of with A inverted
		wr(8'h00, 32'h14);
		setChk(4'he, 1'b1);
		setChk(4'hf, 1'b0);
		// constant sources on cell 1; the power-up pulse is long gone
		wr(8'h04, 32'h3);
		for (int c = 0; c < 3; c++) begin
			wr(8'h05, 32'(c));
			repeat (4) @(posedge clock);
			#1;
			cmpBit(workBit[1], c == 1);
		end
		// delays on cell 0, any-of on condIn[0]
		wr(8'h00, 32'h3);
		setChk(4'h0, 1'b0);
		wr(8'h02, 32'h3);
		wr(8'h03, 32'h2);
		@(posedge clock);
		condIn[0] <= 1'b1;
		#1;
		waitBit(0, 1'b1, n);
		cmpBit(n >= 3 * UNIT && n <= 4 * UNIT + 3, 1'b1);
		@(posedge clock);
		condIn[0] <= 1'b0;
		#1;
		waitBit(0, 1'b0, n);
		cmpBit(n >= 2 * UNIT && n <= 3 * UNIT + 3, 1'b1);
		// a pulse shorter than the on delay never reaches the output
		seen = 1'b0;
		@(posedge clock);
		condIn[0] <= 1'b1;
		repeat (5) @(posedge clock);
		condIn[0] <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clock);
			#1;
			seen = seen | workBit[0];
		end
		cmpBit(seen, 1'b0);
		// delay values above the range are clamped
		wr(8'h02, 32'h3fff);
		rd(8'h02, 32'h270f);
		wr(8'h02, 32'h0);
		wr(8'h03, 32'h0);
		// cell 1 follows work bit of cell 0 two registered stages later
		wr(8'h05, 32'h29);
		@(posedge clock);
		condIn[0] <= 1'b1;
		#1;
		waitBit(0, 1'b1, n);
		cmpBit(workBit[1], 1'b0);
		waitBit(1, 1'b1, n);
		cmpData(32'(n), 32'h2);
		// cell 2 from filtered event pin 0
		wr(8'h08, 32'h3);
		wr(8'h09, 32'h3);
		@(posedge clock);
		evPin[0] <= 1'b1;
		#1;
		waitBit(2, 1'b1, n);
		cmpBit(n <= 8, 1'b1);
		rd(8'h20, 32'h0707);
		results();
	end
endmodule
